/* rtl/tmra_pkg.sv */
// Constants and types for the split-capable PWM timer control block.
// Assumes a 40 MHz peripheral clock and a classic Wishbone master.
package tmra_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRLA  = 6'h00;
  localparam logic [5:0] IDX_CTRLB  = 6'h01;
  localparam logic [5:0] IDX_CTRLD  = 6'h03;
  localparam logic [5:0] IDX_ECLR   = 6'h04;
  localparam logic [5:0] IDX_ESET   = 6'h05;
  localparam logic [5:0] IDX_FCLR   = 6'h06;
  localparam logic [5:0] IDX_FSET   = 6'h07;
  localparam logic [5:0] IDX_EVCTRL = 6'h09;
  localparam logic [5:0] IDX_INTEN  = 6'h0a;
  localparam logic [5:0] IDX_INTFLG = 6'h0b;
  localparam logic [5:0] IDX_CNT    = 6'h20;
  localparam logic [5:0] IDX_PER    = 6'h26;
  localparam logic [5:0] IDX_CMP0   = 6'h28;
  localparam logic [5:0] IDX_PERBUF = 6'h36;
  localparam logic [5:0] IDX_CMPBF0 = 6'h38;
  localparam logic [5:0] IDX_STRIDE = 6'h02;
  // Field positions
  localparam int EN_B = 0;
  localparam int CKS_L = 1;
  localparam int CEN_L = 4;
  localparam int SPL_B = 0;
  localparam int DIR_B = 0;
  localparam int LOCK_UPDATE_B = 1;
  localparam int CMD_L = 2;
  localparam int PBV_B = 0;
  localparam int CBV_L = 1;
  localparam int COUNT_EVENT_INPUT_ENABLE_B = 0;
  localparam int EVA_L = 1;
  localparam int OVF_B = 0;
  localparam int HIGH_BYTE_UNDERFLOW_B = 1;
  localparam int CMPF_L = 4;
  localparam logic [6:0] FLG_MASK = 7'h73;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] W16_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'hffff;
  // Prescaler masks for divide by 1,2,4,8,16,64,256,1024
  localparam logic [9:0] DIV_MASK [8] = '{10'h000, 10'h001, 10'h003,
    10'h007, 10'h00f, 10'h03f, 10'h0ff, 10'h3ff};
  typedef enum logic [1:0] {
    CMD_NONE = 2'b00, CMD_UPDATE = 2'b01,
    CMD_RESTART = 2'b10, CMD_RESET = 2'b11
  } tmra_cmd_e;
  typedef enum logic [2:0] {
    EV_POSEDGE = 3'b000, EV_ANYEDGE = 3'b001,
    EV_HIGHLVL = 3'b010, EV_UPDOWN = 3'b011
  } tmra_event_action_select_e;
  localparam logic [2:0] WG_NORMAL = 3'b000;
  localparam logic [2:0] WG_FRQ    = 3'b001;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tmra_wb_s;
endpackage

/* rtl/tmra_timer.sv */
// Control part of a 16-bit PWM timer: commands, split mode, events,
// interrupt flags and pin override. Wishbone slave, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module tmra_timer
  import tmra_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire tmra_wb_s    wb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [5:0]  port_out_i,
  input  wire logic [5:0]  pin_invert_enable_i,
  output logic [5:0]       pin_o,
  input  wire logic        event_in_i,
  output logic [6:0]       event_o,
  output logic [6:0]       irq_o
);
  logic [7:0]  ctrla_q, ctrlb_q, evctrl_q;
  logic        split_q, dir_q, lock_update_q;
  logic [6:0]  inten_q, flag_q, ev_d, ev_q;
  logic [15:0] cnt_q, per_q, perbuf_q;
  logic [15:0] cmp_q [3];
  logic [15:0] cmpbf_q [3];
  logic        pbv_q;
  logic [2:0]  cbv_q, m_d;
  logic [5:0]  wo_q, pin_q;
  logic [9:0]  pre_q;
  logic        ev_in_q, ack_q;
  logic [31:0] dat_q;

  wire       req  = wb_i.cyc & wb_i.stb;
  wire [5:0] idx  = wb_i.adr[7:2];
  wire       wr   = req & wb_i.we & ack_q;
  wire       wr0  = wr & wb_i.sel[0];
  wire       wr1  = wr & wb_i.sel[1];
  wire       en   = ctrla_q[EN_B];
  wire [2:0] wg   = ctrlb_q[2:0];
  wire [1:0] cmdf = wb_i.dat[CMD_L+:2];
  wire       cmdw = wr0 & (idx == IDX_ESET);
  wire       c_up = cmdw & (cmdf == CMD_UPDATE);
  wire       c_rs = cmdw & (cmdf == CMD_RESTART);
  wire       c_hr = cmdw & (cmdf == CMD_RESET) & ~en;
  wire       hrst = rst_i | c_hr;

  function automatic logic [15:0] wr16(input logic [15:0] old);
    wr16 = {wr1 ? wb_i.dat[15:8] : old[15:8],
            wr0 ? wb_i.dat[7:0] : old[7:0]};
  endfunction

  // Prescaler and event input qualification
  wire tick = en & ((pre_q & DIV_MASK[ctrla_q[CKS_L+:3]])
                    == DIV_MASK[ctrla_q[CKS_L+:3]]);
  wire use_ev = evctrl_q[COUNT_EVENT_INPUT_ENABLE_B] & ~split_q;
  wire [2:0] eva = evctrl_q[EVA_L+:3];
  wire ev_rise = event_in_i & ~ev_in_q;
  wire ev_any  = event_in_i ^ ev_in_q;
  logic step;
  always_comb begin
    step = tick;
    if (use_ev) begin
      unique case (eva)
        EV_POSEDGE: step = en & ev_rise;
        EV_ANYEDGE: step = en & ev_any;
        EV_HIGHLVL: step = tick & event_in_i;
        default:    step = tick;
      endcase
    end
  end
  // Event level drives direction: up while low, down while high
  wire dn = (use_ev && eva == EV_UPDOWN) ? event_in_i : dir_q;

  // Wrap/underflow and compare detection
  wire wrap  = step & (dn ? cnt_q == W16_RST : cnt_q == per_q);
  wire l_unf = tick & (cnt_q[7:0] == W16_RST[7:0]);
  wire h_unf = tick & (cnt_q[15:8] == W16_RST[15:8]);
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      m_d[i] = split_q ? tick & (cnt_q[7:0] == cmp_q[i][7:0])
                       : step & (cnt_q == cmp_q[i]);
    end
    ev_d = '0;
    ev_d[OVF_B]  = split_q ? l_unf : wrap;
    ev_d[HIGH_BYTE_UNDERFLOW_B] = split_q & h_unf;
    ev_d[CMPF_L+:3] = m_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        dat_q <= '0;
        unique case (idx)
          IDX_CTRLA:  dat_q[7:0] <= ctrla_q;
          IDX_CTRLB:  dat_q[7:0] <= ctrlb_q;
          IDX_CTRLD:  dat_q[SPL_B] <= split_q;
          IDX_ECLR, IDX_ESET: begin
            dat_q[DIR_B]  <= dir_q;
            dat_q[LOCK_UPDATE_B] <= lock_update_q;
          end
          IDX_FCLR, IDX_FSET: begin
            dat_q[PBV_B]     <= pbv_q;
            dat_q[CBV_L+:3] <= cbv_q;
          end
          IDX_EVCTRL: dat_q[7:0] <= evctrl_q;
          IDX_INTEN:  dat_q[6:0] <= inten_q;
          IDX_INTFLG: dat_q[6:0] <= flag_q;
          IDX_CNT:    dat_q[15:0] <= cnt_q;
          IDX_PER:    dat_q[15:0] <= per_q;
          IDX_PERBUF: dat_q[15:0] <= perbuf_q;
          default: begin
            for (int i = 0; i < 3; i++) begin
              if (idx == IDX_CMP0 + IDX_STRIDE * 6'(i))
                dat_q[15:0] <= cmp_q[i];
              if (idx == IDX_CMPBF0 + IDX_STRIDE * 6'(i))
                dat_q[15:0] <= cmpbf_q[i];
            end
          end
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Control registers; mode bit change leaves all values alone
  always_ff @(posedge clk_i) begin
    if (hrst) begin
      ctrla_q  <= REG_RST;
      ctrlb_q  <= REG_RST;
      evctrl_q <= REG_RST;
      split_q  <= 1'b0;
      inten_q  <= '0;
      lock_update_q   <= 1'b0;
    end else if (wr0) begin
      if (idx == IDX_CTRLA)  ctrla_q <= wb_i.dat[7:0];
      if (idx == IDX_CTRLB)  ctrlb_q <= wb_i.dat[7:0];
      if (idx == IDX_EVCTRL) evctrl_q <= wb_i.dat[7:0];
      if (idx == IDX_CTRLD)  split_q <= wb_i.dat[SPL_B];
      if (idx == IDX_INTEN)  inten_q <= wb_i.dat[6:0] & FLG_MASK;
      if (idx == IDX_ESET && wb_i.dat[LOCK_UPDATE_B]) lock_update_q <= 1'b1;
      if (idx == IDX_ECLR && wb_i.dat[LOCK_UPDATE_B]) lock_update_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (hrst) begin
      pre_q   <= '0;
      ev_in_q <= 1'b0;
    end else begin
      pre_q   <= en ? pre_q + 10'h001 : '0;
      ev_in_q <= event_in_i;
    end
  end

  // Update condition at wrap unless locked; the command ignores lock.
  // Buffers play no part in split mode.
  wire upd = ~split_q & ((wrap & ~lock_update_q) | c_up);
  always_ff @(posedge clk_i) begin
    if (hrst) begin
      per_q    <= PER_RST;
      perbuf_q <= PER_RST;
      pbv_q    <= 1'b0;
      cbv_q    <= '0;
      for (int i = 0; i < 3; i++) begin
        cmp_q[i]   <= W16_RST;
        cmpbf_q[i] <= W16_RST;
      end
    end else begin
      if (upd && pbv_q) per_q <= perbuf_q;
      if (idx == IDX_PER && (wr0 | wr1)) per_q <= wr16(per_q);
      // Buffer write wins over a same-cycle update clear
      pbv_q <= (pbv_q & ~upd) | ((wr0 | wr1) & idx == IDX_PERBUF);
      if (idx == IDX_PERBUF && (wr0 | wr1)) perbuf_q <= wr16(perbuf_q);
      if (wr0 && idx == IDX_FSET && wb_i.dat[PBV_B]) pbv_q <= 1'b1;
      if (wr0 && idx == IDX_FCLR && wb_i.dat[PBV_B]) pbv_q <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        if (upd && cbv_q[i]) cmp_q[i] <= cmpbf_q[i];
        if (idx == IDX_CMP0 + IDX_STRIDE * 6'(i) && (wr0 | wr1))
          cmp_q[i] <= wr16(cmp_q[i]);
        if (upd) cbv_q[i] <= 1'b0;
        if (wr0 && idx == IDX_FCLR && wb_i.dat[CBV_L+i]) cbv_q[i] <= 1'b0;
        if (wr0 && idx == IDX_FSET && wb_i.dat[CBV_L+i]) cbv_q[i] <= 1'b1;
        if (idx == IDX_CMPBF0 + IDX_STRIDE * 6'(i) && (wr0 | wr1)) begin
          cmpbf_q[i] <= wr16(cmpbf_q[i]);
          cbv_q[i] <= 1'b1;
        end
      end
    end
  end

  // Counter; runs on in Idle sleep since only clk_i gates it.
  always_ff @(posedge clk_i) begin
    if (hrst) begin
      cnt_q <= W16_RST;
      dir_q <= 1'b0;
    end else if (c_rs) begin
      cnt_q <= W16_RST;
      dir_q <= 1'b0;
    end else if (idx == IDX_CNT && (wr0 | wr1)) begin
      cnt_q <= wr16(cnt_q);
    end else begin
      if (wr0 && idx == IDX_ESET && wb_i.dat[DIR_B]) dir_q <= 1'b1;
      if (wr0 && idx == IDX_ECLR && wb_i.dat[DIR_B]) dir_q <= 1'b0;
      if (split_q) begin
        // Two free byte down-counters; dir and events unused
        if (tick) begin
          cnt_q[7:0] <= l_unf ? per_q[7:0] : cnt_q[7:0] - 8'h01;
          cnt_q[15:8] <= h_unf ? per_q[15:8] : cnt_q[15:8] - 8'h01;
        end
      end else if (step) begin
        if (dn) cnt_q <= wrap ? per_q : cnt_q - 16'h0001;
        else    cnt_q <= wrap ? W16_RST : cnt_q + 16'h0001;
      end
    end
  end

  // Waveform outputs; match wins over period start so CMP=BOTTOM is low when counting down in normal mode
  always_ff @(posedge clk_i) begin
    if (hrst || c_rs) begin
      wo_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (split_q) begin
          if (m_d[i]) wo_q[i] <= 1'b1;
          else if (l_unf) wo_q[i] <= 1'b0;
          if (tick && cnt_q[15:8] == cmp_q[i][15:8]) wo_q[3+i] <= 1'b1;
          else if (h_unf) wo_q[3+i] <= 1'b0;
        end else begin
          if (wg == WG_FRQ) begin
            if (m_d[i]) wo_q[i] <= ~wo_q[i];
          end else if (m_d[i]) begin
            wo_q[i] <= 1'b0;
          end else if (wrap) begin
            wo_q[i] <= 1'b1;
          end
          wo_q[3+i] <= 1'b0;
        end
      end
    end
  end

  // Pin override: normal uses enables 6:4, split low 2:0 high 6:4
  logic [5:0] ovr;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ovr[i]   = split_q ? ctrlb_q[i]
                         : ctrlb_q[CEN_L+i] & (wg != WG_NORMAL);
      ovr[3+i] = split_q & ctrlb_q[CEN_L+i];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        pin_q[i] <= ovr[i] ? wo_q[i] ^ pin_invert_enable_i[i]
                           : port_out_i[i];
      end
    end
  end
  assign pin_o = pin_q;

  // Flags and events share ev_d; set wins over write-one clear
  wire [6:0] fclr = (wr0 && idx == IDX_INTFLG) ? wb_i.dat[6:0] : '0;
  always_ff @(posedge clk_i) begin
    if (hrst) begin
      flag_q <= '0;
      ev_q   <= '0;
    end else begin
      flag_q <= (flag_q & ~fclr) | ev_d;
      ev_q   <= ev_d;
    end
  end
  assign event_o = ev_q;
  assign irq_o   = flag_q & inten_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_irq_hold;
    irq_o[OVF_B] && !c_hr
      && !(wr0 && (idx == IDX_INTFLG || idx == IDX_INTEN))
      |=> irq_o[OVF_B];
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("request dropped without clear");
  property p_ev_flag;
    event_o[CMPF_L] |-> flag_q[CMPF_L];
  endproperty
  a_ev_flag: assert property (p_ev_flag)
    else $error("event without flag");
  property p_high_byte_underflow;
    !split_q |=> !event_o[HIGH_BYTE_UNDERFLOW_B];
  endproperty
  a_high_byte_underflow: assert property (p_high_byte_underflow)
    else $error("high underflow event in normal mode");
  property p_restart;
    c_rs |=> cnt_q == W16_RST && wo_q == '0 && !dir_q;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not clear state");
  property p_rst_ign;
    c_rs == 1'b0 && cmdw && cmdf == CMD_RESET && en
      |=> ctrla_q == $past(ctrla_q) && per_q == $past(per_q);
  endproperty
  a_rst_ign: assert property (p_rst_ign)
    else $error("reset command acted while enabled");
  property p_rst_cmd;
    c_hr |=> per_q == PER_RST && flag_q == '0 && !split_q;
  endproperty
  a_rst_cmd: assert property (p_rst_cmd)
    else $error("reset command left state");
  property p_pin;
    !split_q && wg != WG_NORMAL && ctrlb_q[CEN_L]
      |=> pin_o[0] == $past(wo_q[0] ^ pin_invert_enable_i[0]);
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin not overridden");
  property p_update;
    c_up && pbv_q && !split_q && !(wr && idx == IDX_PER)
      |=> per_q == $past(perbuf_q) ##1 !pbv_q || $past(wr);
  endproperty
  a_update: assert property (p_update)
    else $error("update command did not copy period");
endmodule
`default_nettype wire

/* dv/tmra_tb.sv */
// Self-checking bench for the split-capable PWM timer control block.
// Assumes the Wishbone slave acks one request at a time; no partner.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tmra_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  tmra_wb_s    wb_i  = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [5:0]  port_out_i = 6'h00;
  logic [5:0]  pin_invert_enable_i = 6'h00;
  logic [5:0]  pin_o;
  logic        event_in_i = 1'b0;
  logic [6:0]  event_o;
  logic [6:0]  irq_o;
  int          err_count = 0;
  int          cmp_count = 0;
  logic [31:0] rnd = 32'h01b8;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  bit          hit;

  always #12.5 clk_i = ~clk_i;

  tmra_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_out_i(port_out_i),
    .pin_invert_enable_i(pin_invert_enable_i), .pin_o(pin_o),
    .event_in_i(event_in_i), .event_o(event_o), .irq_o(irq_o));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read results are judged when the ack shows up, oldest note first
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_i.we == 1'b0 && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      chk(wb_dat_o, exp_v);
    end
  end

  task automatic bus(input logic [5:0] idx, input logic we,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
              sel: 4'h3, dat: {16'h0000, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    wb_i <= '0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    bus(idx, 1'b0, 16'h0000);
  endtask

  task automatic wait_ev(input int b);
    hit = 1'b0;
    repeat (300) begin
      @(posedge clk_i);
      if (event_o[b] === 1'b1 && !hit) begin
        hit = 1'b1;
        #1 chk({31'h0, irq_o[b]}, 32'h1);
      end
    end
    chk({31'h0, hit}, 32'h1);
  endtask

  task automatic cmd(input logic [1:0] c);
    wr(IDX_ESET, {12'h000, c, 2'b00});
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clk_i) event_in_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      event_in_i <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_CTRLA, 16'h0000);
    rd(IDX_PER, PER_RST);
    rd(6'h3f, 16'h0000);
    // Normal mode: wrap and compare flags with matching events
    wr(IDX_PER, 16'h0007);
    for (int i = 0; i < 3; i++) wr(IDX_CMP0 + 6'(2 * i), 16'(i + 1));
    wr(IDX_INTEN, 16'h0073);
    wr(IDX_CTRLA, 16'h0001);
    wait_ev(0);
    for (int i = 4; i < 7; i++) wait_ev(i);
    // Reset command while running must be ignored
    cmd(CMD_RESET);
    rd(IDX_PER, 16'h0007);
    wr(IDX_CTRLA, 16'h0000);
    wr(IDX_INTFLG, 16'h0073);
    @(posedge clk_i);
    #1 chk({25'h0, irq_o}, 32'h0);
    // Update ignores lock; restart clears counter
    wr(IDX_ESET, 16'h0002);
    wr(IDX_PERBUF, 16'h0012);
    cmd(CMD_UPDATE);
    rd(IDX_PER, 16'h0012);
    wr(IDX_CNT, 16'h0005);
    cmd(CMD_RESTART);
    rd(IDX_CNT, 16'h0000);
    cmd(CMD_RESET);
    rd(IDX_PER, PER_RST);
    rd(IDX_ESET, 16'h0000);
    // Pin override and invert
    rnd = lfsr(rnd);
    port_out_i <= rnd[5:0] | 6'h01;
    wr(IDX_CTRLB, {9'h000, 3'b001, 1'b0, WG_FRQ});
    cmd(CMD_RESTART);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, pin_o[0]}, 32'h0);
    @(posedge clk_i);
    pin_invert_enable_i <= 6'h01;
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, pin_o[0]}, 32'h1);
    @(posedge clk_i);
    pin_invert_enable_i <= 6'h00;
    wr(IDX_CTRLB, {13'h0000, WG_FRQ});
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, pin_o[0]}, 32'h1);
    // Rising and any edge at a slow prescaler, then high level at full rate
    for (int a = 0; a < 3; a++) begin
      cmd(CMD_RESET);
      wr(IDX_EVCTRL, {12'h000, 3'(a), 1'b1});
      wr(IDX_CTRLA, (a == 2) ? 16'h0001 : 16'h000f);
      pulses(3);
      repeat (4) @(posedge clk_i);
      wr(IDX_CTRLA, 16'h0000);
      rd(IDX_CNT, 16'(3 * (a + 1)));
    end
    // Event held high counts down; one divide-by-1024 tick wraps to PER
    cmd(CMD_RESET);
    wr(IDX_EVCTRL, {12'h000, EV_UPDOWN, 1'b1});
    event_in_i <= 1'b1;
    wr(IDX_CTRLA, 16'h000f);
    repeat (1100) @(posedge clk_i);
    wr(IDX_CTRLA, 16'h0000);
    event_in_i <= 1'b0;
    rd(IDX_CNT, PER_RST);
    // Split mode: two byte counters, high underflow event
    cmd(CMD_RESET);
    wr(IDX_CTRLD, 16'h0001);
    wr(IDX_PER, 16'h0302);
    wr(IDX_INTEN, 16'h0003);
    wr(IDX_CTRLA, 16'h0001);
    wait_ev(1);
    wait_ev(0);
    wr(IDX_CTRLA, 16'h0000);
    rd(IDX_CTRLD, 16'h0001);
    repeat (4) @(posedge clk_i);
    wrap_up();
  end

  initial begin
    #(25 * 20000);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
